// [rtl/frame_reader.sv]
// video frame memory reader: memory read master, video stream source, axi4-lite registers
// Notes on behaviour
// - fetch frame pixels from memory, stream them out
// - control packet, then video header, then pixels
// - control packet carries programmed width, height, interlace
// - planes and sample bits fixed; define beat
// - sequence count kept apart, beat unchanged
// - whole patterns per word; top bits ignored
// - lowest-order pattern of a word first
// - start at programmed address, ascending words
// - two frame locations, one selection register
// - one frame-done interrupt per video packet
// - width, height bounded; interlace takes any value
// - up to four parallel, three sequential planes
module frame_reader
    import frame_reader_pkg::*;
#(
    parameter int BPS = 8,
    parameter int PLANES = 3,
    parameter int SEQ = 1,
    parameter int DATA_W = 64,
    parameter logic [15:0] MAX_W = 16'd1920,
    parameter logic [15:0] MAX_H = 16'd1080
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory read master
    output logic [31:0] mm_address_o,
    output logic mm_read_o,
    input wire logic mm_waitrequest_i,
    input wire logic [DATA_W-1:0] mm_readdata_i,
    input wire logic mm_readdatavalid_i,
    // video stream source
    output logic [PLANES*BPS-1:0] st_data_o,
    output logic st_valid_o,
    input wire logic st_ready_i,
    output logic st_sop_o,
    output logic st_eop_o,
    // interrupt
    output logic irq_o
);
    localparam int PAT_W = PLANES * BPS;
    localparam int PPW = DATA_W / PAT_W;
    localparam int CTL_BEATS = (CTL_NIBBLES + PLANES - 1) / PLANES;
    localparam logic [31:0] WORD_BYTES = 32'(DATA_W / 8);

    rd_state_t state_r;
    logic go_r, sel_r, sh_sel_r;
    logic [31:0] loc_addr_r [2];
    logic [31:0] loc_words_r [2];
    logic [31:0] loc_pats_r [2];
    logic [15:0] loc_w_r [2];
    logic [15:0] loc_h_r [2];
    logic [3:0] loc_il_r [2];
    logic [31:0] sh_addr_r, words_left_r, pats_left_r;
    logic [15:0] sh_w_r, sh_h_r;
    logic [3:0] sh_il_r;
    logic [DATA_W-1:0] word_r;
    logic [7:0] slot_r, ctl_beat_r;
    logic [31:0] irq_stat_r, irq_mask_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_held_r, w_held_r;
    logic out_valid_r, out_sop_r, out_eop_r, out_vid_r;
    logic [PAT_W-1:0] out_data_r;

    // output stage can take a beat
    logic load, out_hs, frame_done, wr_go, rd_go, last_pat;
    logic [PAT_W-1:0] beat_data;
    logic beat_sop, beat_eop, beat_vid;
    logic [35:0] ctl_vec;
    assign load = !out_valid_r || st_ready_i;
    assign out_hs = out_valid_r && st_ready_i;
    assign frame_done = out_hs && out_eop_r && out_vid_r;
    assign ctl_vec = {sh_w_r, sh_h_r, sh_il_r};
    assign last_pat = (pats_left_r == 32'd1) ||
                      (slot_r == 8'(PPW - 1) && words_left_r == 32'd0);

    // beat builder: control nibbles per plane, headers, or a pattern
    always_comb begin
        beat_data = '0;
        beat_sop = 1'b0;
        beat_eop = 1'b0;
        beat_vid = 1'b0;
        case (state_r)
            S_CTL: begin
                beat_sop = (ctl_beat_r == 8'd0);
                beat_eop = (ctl_beat_r == 8'(CTL_BEATS));
                if (ctl_beat_r == 8'd0) begin
                    beat_data[3:0] = TYPE_CTRL;
                end else begin
                    for (int p = 0; p < PLANES; p++) begin
                        int k;
                        k = (int'(ctl_beat_r) - 1) * PLANES + p;
                        if (k < CTL_NIBBLES) begin
                            beat_data[p*BPS +: 4] = ctl_vec[35 - 4*k -: 4];
                        end
                    end
                end
            end
            S_VHDR: begin
                beat_sop = 1'b1;
                beat_vid = 1'b1;
                beat_data[3:0] = TYPE_VIDEO;
            end
            S_EMIT: begin
                beat_vid = 1'b1;
                beat_eop = last_pat;
                // low-order pattern first, unused top bits never selected
                beat_data = word_r[slot_r*PAT_W +: PAT_W];
            end
            default: begin
                beat_data = '0;
            end
        endcase
    end

    // registered stream output
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_valid_r <= 1'b0;
            out_sop_r <= 1'b0;
            out_eop_r <= 1'b0;
            out_vid_r <= 1'b0;
            out_data_r <= '0;
        end else if (load) begin
            out_valid_r <= state_r inside {S_CTL, S_VHDR, S_EMIT};
            out_sop_r <= beat_sop;
            out_eop_r <= beat_eop;
            out_vid_r <= beat_vid;
            out_data_r <= beat_data;
        end
    end
    assign st_data_o = out_data_r;
    assign st_valid_o = out_valid_r;
    assign st_sop_o = out_sop_r;
    assign st_eop_o = out_eop_r;

    // frame sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= S_IDLE;
            ctl_beat_r <= 8'h00;
            slot_r <= 8'h00;
            word_r <= '0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    ctl_beat_r <= 8'h00;
                    if (go_r) begin
                        state_r <= S_CTL;
                    end
                end
                S_CTL: begin
                    if (load) begin
                        ctl_beat_r <= ctl_beat_r + 8'h01;
                        if (ctl_beat_r == 8'(CTL_BEATS)) begin
                            state_r <= S_VHDR;
                        end
                    end
                end
                S_VHDR: begin
                    if (load) begin
                        state_r <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (!mm_waitrequest_i) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (mm_readdatavalid_i) begin
                        word_r <= mm_readdata_i;
                        slot_r <= 8'h00;
                        state_r <= S_EMIT;
                    end
                end
                S_EMIT: begin
                    if (load) begin
                        if (last_pat) begin
                            state_r <= S_IDLE;
                        end else if (slot_r == 8'(PPW - 1)) begin
                            state_r <= S_REQ;
                        end else begin
                            slot_r <= slot_r + 8'h01;
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // per-frame snapshot of the selected location and counters
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sh_sel_r <= 1'b0;
            sh_addr_r <= REG_RST;
            sh_w_r <= DIM_RST;
            sh_h_r <= DIM_RST;
            sh_il_r <= ILACE_RST;
            words_left_r <= REG_RST;
            pats_left_r <= REG_RST;
        end else if (state_r == S_IDLE && go_r) begin
            // latched only here, so a running frame never changes
            sh_sel_r <= sel_r;
            sh_addr_r <= loc_addr_r[sel_r];
            sh_w_r <= loc_w_r[sel_r];
            sh_h_r <= loc_h_r[sel_r];
            sh_il_r <= loc_il_r[sel_r];
            words_left_r <= (loc_words_r[sel_r] == 32'd0) ? 32'd1 : loc_words_r[sel_r];
            pats_left_r <= (loc_pats_r[sel_r] == 32'd0) ? 32'd1 : loc_pats_r[sel_r];
        end else begin
            if (state_r == S_REQ && !mm_waitrequest_i) begin
                sh_addr_r <= sh_addr_r + WORD_BYTES;
                words_left_r <= words_left_r - 32'd1;
            end
            if (state_r == S_EMIT && load) begin
                pats_left_r <= pats_left_r - 32'd1;
            end
        end
    end
    assign mm_read_o = (state_r == S_REQ);
    assign mm_address_o = sh_addr_r;

    // axi write path: address and data taken in either order
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= REG_RST;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r[7:2] <= 6'h05 || aw_addr_r[6]) ?
                               RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // register file writes
    logic [31:0] wm;
    logic wloc;
    assign wloc = aw_addr_r[5];
    assign wm = merge(REG_RST, w_data_r, w_strb_r);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            go_r <= 1'b0;
            sel_r <= 1'b0;
            irq_mask_r <= REG_RST;
            for (int i = 0; i < 2; i++) begin
                loc_addr_r[i] <= REG_RST;
                loc_words_r[i] <= REG_RST;
                loc_pats_r[i] <= REG_RST;
                loc_w_r[i] <= DIM_RST;
                loc_h_r[i] <= DIM_RST;
                loc_il_r[i] <= ILACE_RST;
            end
        end else if (wr_go) begin
            if (aw_addr_r[6]) begin
                case (aw_addr_r[4:2])
                    LOC_ADDR_IDX: loc_addr_r[wloc] <= merge(loc_addr_r[wloc], w_data_r, w_strb_r);
                    LOC_WORDS_IDX: loc_words_r[wloc] <= merge(loc_words_r[wloc], w_data_r, w_strb_r);
                    LOC_PATS_IDX: loc_pats_r[wloc] <= merge(loc_pats_r[wloc], w_data_r, w_strb_r);
                    LOC_WIDTH_IDX: loc_w_r[wloc] <= (wm[15:0] > MAX_W) ? MAX_W : wm[15:0];
                    LOC_HEIGHT_IDX: loc_h_r[wloc] <= (wm[15:0] > MAX_H) ? MAX_H : wm[15:0];
                    LOC_ILACE_IDX: loc_il_r[wloc] <= wm[3:0];
                    default: begin
                    end
                endcase
            end else begin
                case ({aw_addr_r[7:2], 2'b00})
                    CTRL_OFS: go_r <= w_strb_r[0] ? w_data_r[CTRL_GO_BIT] : go_r;
                    SELECT_OFS: sel_r <= w_strb_r[0] ? w_data_r[0] : sel_r;
                    IRQ_MASK_OFS: irq_mask_r <= merge(irq_mask_r, w_data_r, w_strb_r);
                    default: begin
                    end
                endcase
            end
        end
    end

    // axi read path, reading the status of interrupts clears it
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= REG_RST;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= REG_RST;
            if (s_axi_araddr[6]) begin
                case (s_axi_araddr[4:2])
                    LOC_ADDR_IDX: s_axi_rdata <= loc_addr_r[s_axi_araddr[5]];
                    LOC_WORDS_IDX: s_axi_rdata <= loc_words_r[s_axi_araddr[5]];
                    LOC_PATS_IDX: s_axi_rdata <= loc_pats_r[s_axi_araddr[5]];
                    LOC_WIDTH_IDX: s_axi_rdata <= {16'h0000, loc_w_r[s_axi_araddr[5]]};
                    LOC_HEIGHT_IDX: s_axi_rdata <= {16'h0000, loc_h_r[s_axi_araddr[5]]};
                    LOC_ILACE_IDX: s_axi_rdata <= {28'h0000000, loc_il_r[s_axi_araddr[5]]};
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else begin
                case ({s_axi_araddr[7:2], 2'b00})
                    CTRL_OFS: s_axi_rdata <= {31'h0, go_r};
                    STATUS_OFS: begin
                        s_axi_rdata[STAT_BUSY_BIT] <= (state_r != S_IDLE);
                        s_axi_rdata[STAT_LOC_BIT] <= sh_sel_r;
                        s_axi_rdata[STAT_PAR_POS +: 4] <= 4'(PLANES);
                        s_axi_rdata[STAT_SEQ_POS +: 4] <= 4'(SEQ);
                    end
                    IRQ_STAT_OFS: s_axi_rdata <= irq_stat_r;
                    IRQ_MASK_OFS: s_axi_rdata <= irq_mask_r;
                    SELECT_OFS: s_axi_rdata <= {31'h0, sel_r};
                    IDENT_OFS: s_axi_rdata <= IDENT_VAL;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // sticky frame-done flag, set wins over read clear
    logic stat_rd;
    assign stat_rd = rd_go && !s_axi_araddr[6] && s_axi_araddr[5:2] == IRQ_STAT_OFS[5:2];
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_stat_r <= REG_RST;
        end else if (frame_done) begin
            irq_stat_r[IRQ_DONE_BIT] <= 1'b1;
        end else if (stat_rd) begin
            irq_stat_r <= REG_RST;
        end
    end
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // checks
    sequence s_ctl_last;
        state_r == S_CTL && load && ctl_beat_r == 8'(CTL_BEATS);
    endsequence
    property p_vhdr_follows;
        @(posedge clk_i) disable iff (srst_i) s_ctl_last |=> state_r == S_VHDR;
    endproperty
    a_vhdr_follows: assert property (p_vhdr_follows) else $error("no video header after control");
    property p_ctl_type;
        @(posedge clk_i) disable iff (srst_i)
            out_valid_r && out_sop_r && !out_vid_r |-> out_data_r[3:0] == TYPE_CTRL;
    endproperty
    a_ctl_type: assert property (p_ctl_type) else $error("control packet type wrong");
    property p_width_nibble;
        @(posedge clk_i) disable iff (srst_i)
            state_r == S_CTL && load && ctl_beat_r == 8'd1 |=> out_data_r[3:0] == sh_w_r[15:12];
    endproperty
    a_width_nibble: assert property (p_width_nibble) else $error("width nibble wrong");
    property p_low_first;
        @(posedge clk_i) disable iff (srst_i)
            state_r == S_EMIT && load && slot_r == 8'd0 |=>
            out_data_r == $past(word_r[PAT_W-1:0]);
    endproperty
    a_low_first: assert property (p_low_first) else $error("low pattern not first");
    property p_addr_step;
        @(posedge clk_i) disable iff (srst_i)
            state_r == S_REQ && !mm_waitrequest_i |=>
            mm_address_o == $past(mm_address_o) + WORD_BYTES;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not ascending");
    property p_irq_once;
        @(posedge clk_i) disable iff (srst_i) frame_done |=> irq_stat_r[IRQ_DONE_BIT];
    endproperty
    a_irq_once: assert property (p_irq_once) else $error("frame done not flagged");
    property p_hold_frame;
        @(posedge clk_i) disable iff (srst_i)
            state_r != S_IDLE ##1 state_r != S_IDLE |-> $stable(sh_w_r) && $stable(sh_sel_r);
    endproperty
    a_hold_frame: assert property (p_hold_frame) else $error("settings changed mid frame");
    property p_select;
        @(posedge clk_i) disable iff (srst_i)
            state_r == S_IDLE && go_r |=> sh_addr_r == $past(loc_addr_r[sel_r]);
    endproperty
    a_select: assert property (p_select) else $error("wrong location taken");
    property p_bounds;
        @(posedge clk_i) disable iff (srst_i)
            loc_w_r[0] <= MAX_W && loc_w_r[1] <= MAX_W && loc_h_r[0] <= MAX_H && loc_h_r[1] <= MAX_H;
    endproperty
    a_bounds: assert property (p_bounds) else $error("dimension above maximum");
    property p_planes;
        @(posedge clk_i) disable iff (srst_i) PLANES <= 4 && SEQ <= 3 && PPW >= 1;
    endproperty
    a_planes: assert property (p_planes) else $error("plane count out of range");
endmodule

// [rtl/frame_reader_pkg.sv]
// shared constants for the video frame memory reader
package frame_reader_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] SELECT_OFS = 8'h10;
    localparam logic [7:0] IDENT_OFS = 8'h14;
    // frame location blocks: bit 6 set, bit 5 picks the location
    localparam logic [7:0] LOC0_BASE = 8'h40;
    localparam logic [7:0] LOC1_BASE = 8'h60;
    // field index (byte offset bits 4:2) inside a location block
    localparam logic [2:0] LOC_ADDR_IDX = 3'h0;
    localparam logic [2:0] LOC_WORDS_IDX = 3'h1;
    localparam logic [2:0] LOC_PATS_IDX = 3'h2;
    localparam logic [2:0] LOC_WIDTH_IDX = 3'h3;
    localparam logic [2:0] LOC_HEIGHT_IDX = 3'h4;
    localparam logic [2:0] LOC_ILACE_IDX = 3'h5;
    // field positions
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LOC_BIT = 1;
    localparam int STAT_PAR_POS = 4;
    localparam int STAT_SEQ_POS = 8;
    localparam int IRQ_DONE_BIT = 0;
    // reset values
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [15:0] DIM_RST = 16'h0000;
    localparam logic [3:0] ILACE_RST = 4'h0;
    // identity word, value arbitrary
    localparam logic [31:0] IDENT_VAL = 32'h0000_5A01;
    // stream packet types and control packet size
    localparam logic [3:0] TYPE_VIDEO = 4'h0;
    localparam logic [3:0] TYPE_CTRL = 4'hF;
    localparam int CTL_NIBBLES = 9;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // reader states
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_CTL = 6'h02,
        S_VHDR = 6'h04,
        S_REQ = 6'h08,
        S_WAIT = 6'h10,
        S_EMIT = 6'h20
    } rd_state_t;
endpackage

// [verification/mem_model.sv]
// memory model answering the frame reader's read master
module mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // read port, slow_i adds stalls and latency
    input wire logic [31:0] addr_i,
    input wire logic rd_i,
    input wire logic slow_i,
    output logic wait_o,
    output logic [63:0] data_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph_r;
    logic busy_r;
    logic [3:0] cnt_r;
    logic [31:0] a_r;
    // stall every other cycle when slow
    assign wait_o = slow_i & ph_r;
    // one read at a time; idle data bus keeps changing
    always_ff @(posedge clk_i) begin
        ph_r <= ~ph_r & ~srst_i;
        valid_o <= 1'b0;
        if (srst_i) begin
            busy_r <= 1'b0;
            data_o <= '1;
        end else if (busy_r && cnt_r == 4'h0) begin
            busy_r <= 1'b0;
            valid_o <= 1'b1;
            data_o <= {16'hFFFF, 8'h01, a_r[15:0], 8'h00, a_r[15:0]}; // top bits unused
        end else begin
            data_o <= ~data_o;
            cnt_r <= cnt_r - 4'h1;
            if (!busy_r && rd_i && !wait_o) begin
                busy_r <= 1'b1;
                a_r <= addr_i;
                cnt_r <= slow_i ? 4'h6 : 4'h0;
            end
        end
    end
endmodule

// [verification/tb_frame_reader.sv]
// self-checking bench for the frame reader
module tb_frame_reader import frame_reader_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, srst_i = 1'b1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, st_ready = 0, slow = 0, awready, wready, bvalid, arready, rvalid;
    logic mm_read, mm_wait, mm_valid, st_valid, st_sop, st_eop, irq;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, mm_addr, d;
    logic [1:0] bresp, rresp, r, rc = 2'h0;
    logic [63:0] mm_data;
    logic [23:0] st_data;
    logic [25:0] got[$], exp_q[$];
    logic [23:0] msk[$];
    int err_total = 0, cmp_count = 0, n;
    // register cases: write flag, address, data, response
    logic [42:0] rows[9] = '{{1'b0, IDENT_OFS, IDENT_VAL, RESP_OKAY},
        {1'b0, STATUS_OFS, 32'h0000_0130, RESP_OKAY}, {1'b0, IRQ_MASK_OFS, REG_RST, RESP_OKAY},
        {1'b0, 8'h18, 32'h0, RESP_SLVERR}, {1'b1, 8'h1C, 32'h1, RESP_SLVERR},
        {1'b1, 8'h4C, 32'h0000_FFFF, RESP_OKAY}, {1'b0, 8'h4C, 32'h0000_0780, RESP_OKAY},
        {1'b1, 8'h74, 32'hF, RESP_OKAY}, {1'b0, 8'h74, 32'hF, RESP_OKAY}};
    always #2.5 clk_i = ~clk_i;
    frame_reader i_frame_reader (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mm_address_o(mm_addr), .mm_read_o(mm_read), .mm_waitrequest_i(mm_wait),
        .mm_readdata_i(mm_data), .mm_readdatavalid_i(mm_valid), .st_data_o(st_data),
        .st_valid_o(st_valid), .st_ready_i(st_ready), .st_sop_o(st_sop), .st_eop_o(st_eop),
        .irq_o(irq));
    mem_model i_mem_model (.clk_i(clk_i), .srst_i(srst_i), .addr_i(mm_addr), .rd_i(mm_read),
        .slow_i(slow), .wait_o(mm_wait), .data_o(mm_data), .valid_o(mm_valid));
    // sink stalls one cycle in four, memory slows for later frames
    always @(posedge clk_i) begin
        rc <= rc + 2'h1;
        st_ready <= rc != 2'h3;
        slow <= got.size() >= 10;
        if (st_valid && st_ready) got.push_back({st_sop, st_eop, st_data});
    end
    task automatic end_of_test();
        $display("mismatches %0d, compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // bounded wait step, gives up after 400 cycles
    task automatic tick(inout int c);
        @(negedge clk_i);
        c++;
        if (c > 400) begin
            err_total++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic pa, pw, ta, tw;
        int c;
        @(posedge clk_i);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        pa = 1'b1; pw = 1'b1; c = 0;
        while (pa || pw) begin
            tick(c);
            ta = pa & awready;
            tw = pw & wready;
            @(posedge clk_i);
            if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
            if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
        end
        do tick(c); while (!bvalid);
        chk(bresp, er);
        @(posedge clk_i);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int c;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1; c = 0;
        do tick(c); while (!arready);
        @(posedge clk_i);
        arvalid <= 1'b0;
        do tick(c); while (!rvalid);
        d = rdata; r = rresp;
        @(posedge clk_i);
        rready <= 1'b0;
        if (er !== 2'h1) chk({d, r}, {e, er});
    endtask
    // program one location and queue the frame it should produce
    task automatic loc(input logic [7:0] b, input logic [31:0] ad, w, p,
                       input logic [15:0] fw, fh, input logic [3:0] il);
        logic [35:0] nib;
        logic [23:0] bt;
        logic [31:0] a;
        nib = {fw, fh, il};
        wr(b, ad, RESP_OKAY);
        wr(b + 8'h04, w, RESP_OKAY);
        wr(b + 8'h08, p, RESP_OKAY);
        wr(b + 8'h0C, {16'h0, fw}, RESP_OKAY);
        wr(b + 8'h10, {16'h0, fh}, RESP_OKAY);
        wr(b + 8'h14, {28'h0, il}, RESP_OKAY);
        exp_q.push_back({2'b10, 24'h00000F});
        msk.push_back(24'h00000F);
        for (int i = 0; i < 3; i++) begin
            bt = '0;
            for (int j = 0; j < 3; j++) bt[j*8 +: 4] = nib[35 - 4*(i*3 + j) -: 4];
            exp_q.push_back({1'b0, 1'(i == 2), bt});
            msk.push_back(24'h0F0F0F);
        end
        exp_q.push_back({2'b10, 24'h000000});
        msk.push_back(24'h00000F);
        for (int k = 0; k < p; k++) begin
            a = ad + 32'(8 * (k / 2));
            exp_q.push_back({1'b0, 1'(k == p - 1), 7'h0, 1'(k % 2), a[15:0]});
            msk.push_back(24'hFFFFFF);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i);
        chk({irq, st_valid, mm_read}, 32'h0);
        foreach (rows[i]) begin
            if (rows[i][42]) wr(rows[i][41:34], rows[i][33:2], rows[i][1:0]);
            else rd(rows[i][41:34], rows[i][33:2], rows[i][1:0]);
        end
        loc(LOC0_BASE, 32'h0000_1000, 32'd3, 32'd5, 16'h0005, 16'h0001, 4'h3);
        loc(LOC1_BASE, 32'h0000_2040, 32'd1, 32'd2, 16'h0123, 16'h0045, 4'hA);
        wr(SELECT_OFS, 32'h0, RESP_OKAY);
        wr(CTRL_OFS, 32'h1, RESP_OKAY);
        wr(SELECT_OFS, 32'h1, RESP_OKAY);
        n = 0;
        do tick(n); while (got.size() < exp_q.size());
        wr(CTRL_OFS, 32'h0, RESP_OKAY);
        n = 0;
        do begin
            rd(STATUS_OFS, 32'h0, 2'h1);
            tick(n);
        end while (d[0] !== 1'b0);
        foreach (exp_q[i]) chk({got[i][25:24], got[i][23:0] & msk[i]}, exp_q[i]);
        chk(irq, 32'h0);
        wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
        @(negedge clk_i);
        chk(irq, 32'h1);
        rd(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
        @(negedge clk_i);
        chk(irq, 32'h0);
        rd(IRQ_STAT_OFS, 32'h0, RESP_OKAY);
        end_of_test();
    end
endmodule
